// file: verilog/bst_pkg.sv
// constants and types for the boundary-scan test access port
// assumes one core clock that oversamples the test clock pin
package bst_pkg;

  // ==========================================================
  // register lengths
  localparam int IR_LEN = 3;
  localparam int BSR_LEN_SMALL = 522;
  localparam int BSR_LEN_MID = 621;
  localparam int BSR_LEN_LARGE = 666;
  localparam int SYNC_LEN = 3;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // instruction codes and fixed capture value
  localparam logic [IR_LEN-1:0] OP_EXTEST = 3'h0;
  localparam logic [IR_LEN-1:0] OP_SAMPLE = 3'h5;
  localparam logic [IR_LEN-1:0] OP_BYPASS = 3'h7;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 3'h1;

  // ==========================================================
  // controller states
  typedef enum logic [3:0] {
    st_tlr, st_rti, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr, st_ex2_dr,
    st_up_dr, st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pa_ir, st_ex2_ir, st_up_ir
  } bst_state_t;

endpackage

// file: verilog/bst_tap.sv
// boundary-scan test access port with a small fifo on the scan-out path
// assumes tck, tms, tdi arrive as pins from another clock domain,
// cfg_busy comes from configuration logic on core_clk
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// fifo
module bst_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = bst_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q] = in_data;
    end
    wr_d = push ? ptr_inc(wr_q) : wr_q;
    rd_d = pop ? ptr_inc(rd_q) : rd_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end
endmodule

// ==========================================================
// test access port
module bst_tap #(
  parameter int BSR_LEN = bst_pkg::BSR_LEN_SMALL
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // test pins, with pad drive sense
  input wire logic tck_pin,
  input wire logic tck_drv,
  input wire logic tms_pin,
  input wire logic tms_drv,
  input wire logic tdi_pin,
  input wire logic tdi_drv,
  output logic tdo_o,
  output logic tdo_oe,
  // device state
  input wire logic cfg_busy,
  // boundary cells
  input wire logic [BSR_LEN-1:0] pin_in,
  input wire logic [BSR_LEN-1:0] core_out,
  output logic [BSR_LEN-1:0] pin_out,
  output logic test_mode
);
  localparam int IR_LEN = bst_pkg::IR_LEN;
  localparam int SL = bst_pkg::SYNC_LEN;

  function automatic logic is_shift(input bst_pkg::bst_state_t s);
    is_shift = (s == bst_pkg::st_sh_dr) || (s == bst_pkg::st_sh_ir);
  endfunction

  function automatic bst_pkg::bst_state_t tap_next(input bst_pkg::bst_state_t s,
                                                    input logic m);
    unique case (s)
      bst_pkg::st_tlr: tap_next = m ? bst_pkg::st_tlr : bst_pkg::st_rti;
      bst_pkg::st_rti: tap_next = m ? bst_pkg::st_sel_dr : bst_pkg::st_rti;
      bst_pkg::st_sel_dr: tap_next = m ? bst_pkg::st_sel_ir : bst_pkg::st_cap_dr;
      bst_pkg::st_cap_dr: tap_next = m ? bst_pkg::st_ex1_dr : bst_pkg::st_sh_dr;
      bst_pkg::st_sh_dr: tap_next = m ? bst_pkg::st_ex1_dr : bst_pkg::st_sh_dr;
      bst_pkg::st_ex1_dr: tap_next = m ? bst_pkg::st_up_dr : bst_pkg::st_pa_dr;
      bst_pkg::st_pa_dr: tap_next = m ? bst_pkg::st_ex2_dr : bst_pkg::st_pa_dr;
      bst_pkg::st_ex2_dr: tap_next = m ? bst_pkg::st_up_dr : bst_pkg::st_sh_dr;
      bst_pkg::st_up_dr: tap_next = m ? bst_pkg::st_sel_dr : bst_pkg::st_rti;
      bst_pkg::st_sel_ir: tap_next = m ? bst_pkg::st_tlr : bst_pkg::st_cap_ir;
      bst_pkg::st_cap_ir: tap_next = m ? bst_pkg::st_ex1_ir : bst_pkg::st_sh_ir;
      bst_pkg::st_sh_ir: tap_next = m ? bst_pkg::st_ex1_ir : bst_pkg::st_sh_ir;
      bst_pkg::st_ex1_ir: tap_next = m ? bst_pkg::st_up_ir : bst_pkg::st_pa_ir;
      bst_pkg::st_pa_ir: tap_next = m ? bst_pkg::st_ex2_ir : bst_pkg::st_pa_ir;
      bst_pkg::st_ex2_ir: tap_next = m ? bst_pkg::st_up_ir : bst_pkg::st_sh_ir;
      bst_pkg::st_up_ir: tap_next = m ? bst_pkg::st_sel_dr : bst_pkg::st_rti;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers, bit 2 tck, bit 1 tms, bit 0 tdi
  logic [SL-1:0] raw;
  logic [SL-1:0] s1_q, s2_q, s3_q, lv_q, lv_d;
  logic rise, fall, tms_lv, tdi_lv;

  // pull-ups: a pin nobody drives reads high
  assign raw = {tck_drv ? tck_pin : 1'b1, tms_drv ? tms_pin : 1'b1,
                tdi_drv ? tdi_pin : 1'b1};

  always_comb begin
    for (int i = 0; i < SL; i++) begin
      lv_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lv_q[i];
    end
  end

  assign rise = s2_q[2] && s3_q[2] && !lv_q[2];
  assign fall = !s2_q[2] && !s3_q[2] && lv_q[2];
  assign tms_lv = lv_q[1];
  assign tdi_lv = lv_q[0];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      lv_q <= '1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lv_q <= lv_d;
    end
  end

  // ==========================================================
  // controller and scan registers
  bst_pkg::bst_state_t st_q, st_d;
  logic [IR_LEN-1:0] ir_q, ir_d, irs_q, irs_d;
  logic byp_q, byp_d;
  logic [BSR_LEN-1:0] bsr_q, bsr_d, upd_q, upd_d, pin_out_q, pin_out_d;
  logic tdo_q, tdo_d, oe_q, oe_d, mode_q, mode_d;
  logic so_bit, ext, fifo_in_ready, fifo_out_valid, fifo_out_data, push, step;

  // unknown codes fall back to bypass
  assign ext = (ir_q == bst_pkg::OP_EXTEST);
  assign so_bit = (st_q == bst_pkg::st_sh_ir) ? irs_q[0] :
                  (ir_q == bst_pkg::OP_EXTEST || ir_q == bst_pkg::OP_SAMPLE) ?
                  bsr_q[0] : byp_q;
  // a full fifo would drop the falling edge push; never fills with a free drain
  assign push = fall && is_shift(st_q);
  assign step = rise;

  always_comb begin
    st_d = st_q;
    ir_d = ir_q;
    irs_d = irs_q;
    byp_d = byp_q;
    bsr_d = bsr_q;
    upd_d = upd_q;
    tdo_d = tdo_q;
    oe_d = oe_q;
    if (step) begin
      st_d = tap_next(st_q, tms_lv);
      unique case (st_q)
        bst_pkg::st_tlr: ir_d = bst_pkg::OP_BYPASS;
        bst_pkg::st_cap_ir: irs_d = bst_pkg::IR_CAPTURE;
        bst_pkg::st_sh_ir: irs_d = {tdi_lv, irs_q[IR_LEN-1:1]};
        bst_pkg::st_up_ir: ir_d = irs_q;
        bst_pkg::st_cap_dr: begin
          byp_d = 1'b0;
          bsr_d = pin_in;
        end
        bst_pkg::st_sh_dr: begin
          if (ir_q == bst_pkg::OP_EXTEST || ir_q == bst_pkg::OP_SAMPLE) begin
            bsr_d = {tdi_lv, bsr_q[BSR_LEN-1:1]};
          end else begin
            byp_d = tdi_lv;
          end
        end
        bst_pkg::st_up_dr: begin
          if (ir_q == bst_pkg::OP_EXTEST || ir_q == bst_pkg::OP_SAMPLE) begin
            upd_d = bsr_q;
          end
        end
        default: ;
      endcase
    end
    if (fall) begin
      oe_d = is_shift(st_q);
    end
    if (fifo_out_valid) begin
      tdo_d = fifo_out_data;
    end
    if (cfg_busy) begin
      st_d = bst_pkg::st_tlr;
      ir_d = bst_pkg::OP_BYPASS;
      oe_d = 1'b0;
    end
    mode_d = ext;
    pin_out_d = ext ? upd_q : core_out;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= bst_pkg::st_tlr;
      ir_q <= bst_pkg::OP_BYPASS;
      irs_q <= '0;
      byp_q <= 1'b0;
      bsr_q <= '0;
      upd_q <= '0;
      pin_out_q <= '0;
      tdo_q <= 1'b1;
      oe_q <= 1'b0;
      mode_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ir_q <= ir_d;
      irs_q <= irs_d;
      byp_q <= byp_d;
      bsr_q <= bsr_d;
      upd_q <= upd_d;
      pin_out_q <= pin_out_d;
      tdo_q <= tdo_d;
      oe_q <= oe_d;
      mode_q <= mode_d;
    end
  end

  // ==========================================================
  // scan-out buffer, tdo follows a falling edge by a few core cycles
  bst_fifo #(
    .WIDTH(1),
    .DEPTH(bst_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(so_bit),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
  );

  assign tdo_o = tdo_q;
  assign tdo_oe = oe_q;
  assign pin_out = pin_out_q;
  assign test_mode = mode_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_CFG_HOLD: assert property (cfg_busy |=> st_q == bst_pkg::st_tlr && !oe_q)
    else $error("scan not held during configuration");
  AST_SAMPLE_PASS: assert property (ir_q == bst_pkg::OP_SAMPLE ##1 ir_q == bst_pkg::OP_SAMPLE
    |-> pin_out_q == $past(core_out))
    else $error("sample disturbed pins");
  AST_EXT_DRIVE: assert property (ir_q == bst_pkg::OP_EXTEST ##1 ir_q == bst_pkg::OP_EXTEST
    |-> pin_out_q == $past(upd_q) && test_mode)
    else $error("extest pattern not on pins");
  AST_BYP_ONE: assert property (rise && st_q == bst_pkg::st_sh_dr &&
    ir_q == bst_pkg::OP_BYPASS && !cfg_busy |=> byp_q == $past(tdi_lv))
    else $error("bypass cell did not take tdi");
  AST_IR_CAP: assert property (rise && st_q == bst_pkg::st_cap_ir && !cfg_busy
    |=> irs_q == bst_pkg::IR_CAPTURE)
    else $error("ir capture value wrong");
  AST_BSR_IN: assert property (rise && st_q == bst_pkg::st_sh_dr && !cfg_busy &&
    ir_q == bst_pkg::OP_EXTEST |=> bsr_q[BSR_LEN-1] == $past(tdi_lv))
    else $error("boundary register did not shift at full length");
  AST_PULLUP: assert property (!tms_drv [*5] |=> tms_lv)
    else $error("undriven tms not read as one");
  AST_TDO_Z: assert property (fall && !is_shift(st_q) |=> !tdo_oe)
    else $error("tdo driven outside shift");
  AST_PUSH_ROOM: assert property (push |-> fifo_in_ready)
    else $error("scan-out buffer overflow");
endmodule

`default_nettype wire

// file: verification/bst_ctl_model.sv
// test controller model: drives tck, tms, tdi and samples tdo
// assumes the tap oversamples the pins; tck period 125 ns
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// controller
module bst_ctl_model (
  // test pins
  output logic tck_pin,
  output logic tck_drv,
  output logic tms_pin,
  output logic tms_drv,
  output logic tdi_pin,
  output logic tdi_drv,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  // sampled scan-out
  output logic got,
  output logic got_bit
);
  logic tms_free = 1'b0;
  initial begin
    tck_pin = 1'b0;
    tck_drv = 1'b1;
    tms_pin = 1'b1;
    tms_drv = 1'b1;
    tdi_pin = 1'b1;
    tdi_drv = 1'b1;
    got = 1'b0;
    got_bit = 1'b0;
  end
  // tck stands low between ticks; tdo sampled late in the high phase
  task automatic tick(input logic tms, input logic tdi);
    tms_drv = !tms_free;
    tms_pin = tms_free ? !tms_pin : tms;
    tdi_pin = tdi;
    #62.5 tck_pin = 1'b1;
    // a released tdo floats up to its pull-up level
    #62.0 got_bit = tdo_oe ? tdo_o : 1'b1;
    got = tdo_oe;
    #0.5 tck_pin = 1'b0;
    got = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verification/bst_tap_bench.sv
// self-checking bench for the test access port
// assumes bst_pkg and bst_tap compiled first, bst_ctl_model beside it
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench
module bst_tap_bench;
  localparam int BL = bst_pkg::BSR_LEN_SMALL;
  localparam int CEIL = 60000;
  logic core_clk, rst_n, cfg_busy, tdo_o, tdo_oe, test_mode, got, got_bit;
  logic tck_pin, tck_drv, tms_pin, tms_drv, tdi_pin, tdi_drv;
  logic [BL-1:0] pin_in, core_out, pin_out, pat, pat2;
  logic expq[$];
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;

  bst_tap #(.BSR_LEN(BL)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .tck_pin(tck_pin),
    .tck_drv(tck_drv), .tms_pin(tms_pin), .tms_drv(tms_drv), .tdi_pin(tdi_pin),
    .tdi_drv(tdi_drv), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .cfg_busy(cfg_busy),
    .pin_in(pin_in), .core_out(core_out), .pin_out(pin_out), .test_mode(test_mode));
  bst_ctl_model u_ctl (.tck_pin(tck_pin), .tck_drv(tck_drv), .tms_pin(tms_pin),
    .tms_drv(tms_drv), .tdi_pin(tdi_pin), .tdi_drv(tdi_drv), .tdo_o(tdo_o),
    .tdo_oe(tdo_oe), .got(got), .got_bit(got_bit));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [BL-1:0] seen, input logic [BL-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, well above the ~14k cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == CEIL) begin
      bad_count++;
      report_and_stop();
    end
  end

  // each driven tdo bit is matched against the oldest note
  always @(posedge got) begin
    if (expq.size() == 0) begin
      check("tdo_oe outside shift", 1'b1, 1'b0);
    end else begin
      check("tdo", got_bit, expq.pop_front());
    end
  end

  task automatic rnd(output logic [BL-1:0] v);
    for (int i = 0; i < BL; i++) begin
      v[i] = 1'($urandom);
    end
  endtask

  task automatic new_pins();
    @(posedge core_clk);
    #1 rnd(pin_in);
    rnd(core_out);
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  // from run-test-idle through capture, shift, update and back
  task automatic scan(input logic ir, input int n, input logic [BL-1:0] din,
                      input logic [BL-1:0] exp);
    u_ctl.tick(1'b1, 1'b0);
    if (ir) begin
      u_ctl.tick(1'b1, 1'b0);
    end
    u_ctl.tick(1'b0, 1'b0);
    u_ctl.tick(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      expq.push_back(exp[i]);
      u_ctl.tick(i == n - 1, din[i]);
    end
    u_ctl.tick(1'b1, 1'b0);
    u_ctl.tick(1'b0, 1'b0);
    #300;
  endtask

  task automatic load_ir(input logic [2:0] op);
    scan(1'b1, 3, op, bst_pkg::IR_CAPTURE);
  endtask

  initial begin
    rst_n = 1'b0;
    cfg_busy = 1'b0;
    pin_in = '0;
    core_out = '0;
    void'($urandom(13234));
    repeat (16) @(posedge core_clk);
    #1 rst_n = 1'b1;
    new_pins();
    check("pin_out after reset", pin_out, core_out);
    u_ctl.tick(1'b0, 1'b0);
    load_ir(bst_pkg::OP_BYPASS);
    rnd(pat);
    scan(1'b0, 16, pat, {pat[BL-2:0], 1'b0});
    $display("bypass test done");
    load_ir(bst_pkg::OP_SAMPLE);
    new_pins();
    scan(1'b0, BL, pat, pin_in);
    check("pin_out sample", pin_out, core_out);
    check("test_mode sample", test_mode, 1'b0);
    $display("sample test done");
    load_ir(bst_pkg::OP_EXTEST);
    check("test_mode extest", test_mode, 1'b1);
    check("pin_out preload", pin_out, pat);
    new_pins();
    rnd(pat2);
    scan(1'b0, BL, pat2, pin_in);
    check("pin_out extest", pin_out, pat2);
    $display("extest test done");
    @(posedge core_clk);
    #1 cfg_busy = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 check("test_mode busy", test_mode, 1'b0);
    // a tms walk that would reach shift-ir must leave tdo undriven
    foreach (pat2[i]) if (i < 7) u_ctl.tick(i inside {1, 2}, 1'b0);
    check("tdo_oe busy", tdo_oe, 1'b0);
    @(posedge core_clk);
    #1 cfg_busy = 1'b0;
    u_ctl.tick(1'b0, 1'b0);
    u_ctl.tms_free = 1'b1;
    repeat (5) u_ctl.tick(1'b0, 1'b0);
    u_ctl.tms_free = 1'b0;
    u_ctl.tick(1'b0, 1'b0);
    rnd(pat);
    scan(1'b0, 8, pat, {pat[BL-2:0], 1'b0});
    check("pin_out after busy", pin_out, core_out);
    check("notes left", 32'(expq.size()), 0);
    $display("config and pull-up test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
